//--- spm_defs.svh
// Register map, field positions, codes and timing for the port mode block
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SPM_OFS_CTL      8'h00
`define SPM_OFS_STS      8'h04
`define SPM_OFS_PHY      8'h08
`define SPM_OFS_BRG      8'h0C
`define SPM_OFS_PART     8'h20
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPM_CTL_MODE     1:0
`define SPM_CTL_ACT      5:4
`define SPM_CTL_PSEL_LO  8
`define SPM_CTL_DEV      20:16
`define SPM_STS_INIT     0
`define SPM_STS_DONE     1
`define SPM_STS_BUSY     2
`define SPM_STS_MODE     5:4
`define SPM_PHY_ISCC     0
`define SPM_BRG_BUS      7:0
`define SPM_BRG_DEV      12:8
`define SPM_BRG_T1       16
`define SPM_PART_STATE   1:0
// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define SPM_MODE_DIS     2'h0
`define SPM_MODE_UP      2'h1
`define SPM_MODE_DN      2'h2
`define SPM_MODE_UNATT   2'h3
`define SPM_ACT_NONE     2'h0
`define SPM_ACT_RESET    2'h1
`define SPM_PART_DIS     2'h0
`define SPM_PART_ACTIVE  2'h1
`define SPM_DEV_RST      5'h00
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SPM_CLK_MHZ      100
`define SPM_T_NOACT_US   2000
`define SPM_T_RESET_US   2500
`endif

//--- spm_pkg.sv
// Types shared by the port mode block
package spm_pkg;
   // Effective operating mode of the port
   typedef enum logic [3:0] {
      SPM_DIS   = 4'h1,
      SPM_UP    = 4'h2,
      SPM_DN    = 4'h4,
      SPM_UNATT = 4'h8
   } spm_mode_e;
   // Mode change sequencer
   typedef enum logic [1:0] {
      SPM_IDLE = 2'h1,
      SPM_BUSY = 2'h2
   } spm_mc_e;
endpackage : spm_pkg

//--- spm_port_mode.sv
// Operating mode control of one switch port, with Wishbone registers
// What this block does
// - Unattached: general registers act downstream, link registers upstream
// - Unattached: ignore hot reset, DL_Down and slot power limit messages
// - Unattached: no automatic speed change unless the phy config bit allows
// - Upstream mode holds downstream outputs, hot-plug too, negated
// - Upstream bridge shows type 1 header, device zero, function zero
// - Upstream mode: link training active, behaving as upstream port
// - Downstream mode: type 1 header, link training active as downstream
// - Downstream device number comes from control field; function always zero
// - Config write applies new device number; completion carries old one
// - Register-side device number change leaves captured numbers alone
// - Mode follows control fields and partition state; boot strap at reset
// - Any change of mode, partition or device field after boot starts a mode change
// - Writing the same field values starts nothing
// - Associated partition set to disabled counts as a mode change
// - Same-partition change on disabled port runs change, stays disabled
// - Mode field disabled detaches port; change actions still run
// - New partition select detaches; mode then follows new partition
// - Initiated flag set when a mode change begins
// - Completed flag set when a mode change finishes
// - Change takes 2 ms with no action, 2.5 ms with reset
`timescale 1ns/1ns
`include "spm_defs.svh"
module spm_port_mode #(
   parameter int NPART     = 8,
   parameter int PSELW     = 3,
   parameter int CNTW      = 18,
   parameter int LAT_NOACT = `SPM_T_NOACT_US * `SPM_CLK_MHZ,
   parameter int LAT_RESET = `SPM_T_RESET_US * `SPM_CLK_MHZ,
   parameter bit HP_ATTN_NEG = 1'b1,
   parameter bit HP_RST_NEG  = 1'b1
) (
   input  wire logic             clk,              // Core clock
   input  wire logic             rst,              // Sync reset, high
   input  wire logic             ce,               // Clock enable
   input  wire logic [7:0]       wb_adr_i,         // Byte address
   input  wire logic [31:0]      wb_dat_i,         // Write data
   input  wire logic [3:0]       wb_sel_i,         // Byte enables
   input  wire logic             wb_we_i,          // Write
   input  wire logic             wb_cyc_i,         // Cycle
   input  wire logic             wb_stb_i,         // Strobe
   output logic      [31:0]      wb_dat_o,         // Read data
   output logic                  wb_ack_o,         // Acknowledge
   input  wire logic [1:0]       bootSwitchMode,   // Boot strap pins
   input  wire logic             cfgWrStb,         // Config write, port_device_number
   input  wire logic [4:0]       cfgWrDevNum,      // New device number
   input  wire logic             type0WrStb,       // Type 0 write seen
   input  wire logic [7:0]       type0WrBus,       // Bus number captured
   input  wire logic             dsAttnReq,        // Attention, asserted
   input  wire logic             dsSlotRstReq,     // Slot reset, asserted
   output logic                  cplStb,           // Config completion
   output logic      [4:0]       cplDevNum,        // Completer device
   output logic      [3:0]       portMode,         // One-hot mode
   output logic                  modeBusy,         // Change in progress
   output logic                  portReset,        // Reset action active
   output logic                  ltssmEnable,      // Link training on
   output logic                  ltssmDownstream,  // Link as downstream
   output logic                  hdrType1,         // Type 1 header
   output logic                  regDsProfile,     // Downstream registers
   output logic                  linkUsProfile,    // Upstream link regs
   output logic                  ignoreHotReset,   // Drop hot-reset TS1
   output logic                  ignoreDlDown,     // Drop DL_Down
   output logic                  ignoreSlotPwr,    // Drop slot power msg
   output logic                  autoSpeedChgEn,   // Speed change at L0
   output logic      [7:0]       capturedBus,      // Bridge bus number
   output logic      [4:0]       capturedDev,      // Bridge device number
   output logic                  hotplugAttentionInd, // Attention pin
   output logic                  hotplugSlotReset  // Slot reset pin
);
   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (NPART < 1 || NPART > (1 << PSELW) || NPART > 24)
      $error("NPART does not fit the partition select or register map");
   if (LAT_RESET >= (1 << CNTW) || LAT_NOACT >= (1 << CNTW) ||
       LAT_NOACT < 1 || LAT_RESET < 1)
      $error("Latency counts do not fit the counter");

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [31:0]             wbDat;
      logic                    wbAck;
      logic [2:0][1:0]         bootSync;
      logic                    booted;
      logic [1:0]              bootFill;
      logic [1:0]              mode;
      logic [1:0]              act;
      logic [PSELW-1:0]        psel;
      logic [4:0]              dev;
      logic [NPART-1:0][1:0]   partState;
      logic                    iscc;
      logic                    initFlag;
      logic                    doneFlag;
      spm_pkg::spm_mc_e        mc;
      logic [CNTW-1:0]         cnt;
      logic                    cntAct;
      spm_pkg::spm_mode_e      active;
      logic                    cplStb;
      logic [4:0]              cplDev;
      logic [7:0]              capBus;
      logic [4:0]              capDev;
      logic                    hpAttn;
      logic                    hpRst;
      logic [11:0]             outs;
   } spm_state_s;

   localparam logic [CNTW-1:0] CNT_NOACT = CNTW'(LAT_NOACT - 1);
   localparam logic [CNTW-1:0] CNT_RESET = CNTW'(LAT_RESET - 1);

   spm_state_s r;
   spm_state_s next_r;
   logic [NPART-1:0] partHit;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Mode from control fields and partition state
   function automatic spm_pkg::spm_mode_e effMode(
      input logic [1:0] m,
      input logic [1:0] pst
   );
      spm_pkg::spm_mode_e e;
      e = spm_pkg::SPM_DIS;
      case (m)
         `SPM_MODE_UNATT: e = spm_pkg::SPM_UNATT;
         `SPM_MODE_UP:    e = spm_pkg::SPM_UP;
         `SPM_MODE_DN:    e = spm_pkg::SPM_DN;
         default:         e = spm_pkg::SPM_DIS;
      endcase
      // Attached port follows its partition's disable
      if ((m == `SPM_MODE_UP || m == `SPM_MODE_DN) &&
          pst == `SPM_PART_DIS)
         e = spm_pkg::SPM_DIS;
      return e;
   endfunction : effMode

   // Status code of an effective mode
   function automatic logic [1:0] modeCode(input spm_pkg::spm_mode_e e);
      logic [1:0] c;
      c = `SPM_MODE_DIS;
      case (e)
         spm_pkg::SPM_UP:    c = `SPM_MODE_UP;
         spm_pkg::SPM_DN:    c = `SPM_MODE_DN;
         spm_pkg::SPM_UNATT: c = `SPM_MODE_UNATT;
         default:            c = `SPM_MODE_DIS;
      endcase
      return c;
   endfunction : modeCode

   // ----------------------------------------------------------------------
   // Partition register decode
   // ----------------------------------------------------------------------
   // One address match per partition
   for (genvar g = 0; g < NPART; g++) begin : gPart
      assign partHit[g] = (wb_adr_i == 8'(`SPM_OFS_PART + 4 * g));
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic             wbReq;
      logic             wr;
      logic [1:0]       nm;
      logic [PSELW-1:0] ns;
      logic [4:0]       nd;
      logic             chg;
      logic             partDis;
      logic             attached;
      logic [31:0]      rd;
      spm_pkg::spm_mode_e em;
      wbReq    = 1'b0;
      wr       = 1'b0;
      nm       = 2'h0;
      ns       = '0;
      nd       = 5'h00;
      chg      = 1'b0;
      partDis  = 1'b0;
      attached = 1'b0;
      rd       = 32'h0000_0000;
      em       = spm_pkg::SPM_DIS;
      next_r   = r;
      next_r.cplStb = 1'b0;

      // Strap synchroniser, filled before the one-time capture
      next_r.bootSync = {r.bootSync[1:0], bootSwitchMode};
      if (!(&r.bootFill))
         next_r.bootFill = r.bootFill + 2'h1;
      if (!r.booted && (&r.bootFill) &&
          r.bootSync[1] == r.bootSync[2]) begin
         next_r.booted = 1'b1;
         next_r.mode   = r.bootSync[2];
         next_r.active = effMode(r.bootSync[2],
                                 r.partState[r.psel]);
      end

      // Wishbone single-cycle answer
      wbReq = wb_cyc_i && wb_stb_i && !r.wbAck;
      wr    = wbReq && wb_we_i;
      next_r.wbAck = wbReq;

      // Control field writes
      nm = r.mode;
      ns = r.psel;
      nd = r.dev;
      if (wr && wb_adr_i == `SPM_OFS_CTL) begin
         if (wb_sel_i[0]) begin
            nm          = wb_dat_i[`SPM_CTL_MODE];
            next_r.act  = wb_dat_i[`SPM_CTL_ACT];
         end
         if (wb_sel_i[1])
            ns = wb_dat_i[`SPM_CTL_PSEL_LO +: PSELW];
         if (wb_sel_i[2])
            nd = wb_dat_i[`SPM_CTL_DEV];
      end

      // Config write path: apply, then complete with old number
      if (cfgWrStb) begin
         nd              = cfgWrDevNum;
         next_r.cplStb   = 1'b1;
         next_r.cplDev   = r.dev;
      end

      // Phy link configuration
      if (wr && wb_adr_i == `SPM_OFS_PHY && wb_sel_i[0])
         next_r.iscc = wb_dat_i[`SPM_PHY_ISCC];

      // Partition state writes
      for (int i = 0; i < NPART; i++) begin
         if (wr && partHit[i] && wb_sel_i[0])
            next_r.partState[i] = wb_dat_i[`SPM_PART_STATE];
      end

      // Status flag clear, write one to clear
      if (wr && wb_adr_i == `SPM_OFS_STS && wb_sel_i[0]) begin
         if (wb_dat_i[`SPM_STS_INIT])
            next_r.initFlag = 1'b0;
         if (wb_dat_i[`SPM_STS_DONE])
            next_r.doneFlag = 1'b0;
      end

      // Mode change detection
      chg = (nm != r.mode) || (ns != r.psel) || (nd != r.dev);
      attached = (r.mode == `SPM_MODE_UP) || (r.mode == `SPM_MODE_DN);
      partDis  = attached &&
                 next_r.partState[r.psel] == `SPM_PART_DIS &&
                 r.partState[r.psel] != `SPM_PART_DIS;
      next_r.mode = r.booted ? nm : next_r.mode;
      next_r.psel = ns;
      next_r.dev  = nd;

      // Mode change sequencer; set wins over clear
      em = effMode(next_r.mode, next_r.partState[ns]);
      case (r.mc)
         spm_pkg::SPM_IDLE: begin
            if (r.active != em && !chg && !partDis && r.booted)
               next_r.active = em;
         end
         spm_pkg::SPM_BUSY: begin
            if (r.cnt == '0) begin
               next_r.mc       = spm_pkg::SPM_IDLE;
               next_r.active   = em;
               next_r.doneFlag = 1'b1;
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         default: next_r.mc = spm_pkg::SPM_IDLE;
      endcase
      if (r.booted && (chg || partDis)) begin
         next_r.mc       = spm_pkg::SPM_BUSY;
         next_r.initFlag = 1'b1;
         next_r.cntAct   = (next_r.act == `SPM_ACT_RESET);
         next_r.cnt      = (next_r.act == `SPM_ACT_RESET) ?
                           CNT_RESET : CNT_NOACT;
      end

      // Bridge number capture on Type 0 write only
      if (type0WrStb) begin
         next_r.capBus = type0WrBus;
         next_r.capDev = (r.active == spm_pkg::SPM_UP) ?
                         `SPM_DEV_RST : r.dev;
      end

      // Hot-plug outputs, negated unless downstream
      if (next_r.active == spm_pkg::SPM_DN) begin
         next_r.hpAttn = dsAttnReq ? ~HP_ATTN_NEG : HP_ATTN_NEG;
         next_r.hpRst  = dsSlotRstReq ? ~HP_RST_NEG : HP_RST_NEG;
      end else begin
         next_r.hpAttn = HP_ATTN_NEG;
         next_r.hpRst  = HP_RST_NEG;
      end

      // Mode-derived controls
      em = next_r.active;
      next_r.outs[0]  = next_r.mc == spm_pkg::SPM_BUSY;
      next_r.outs[1]  = next_r.outs[0] && next_r.cntAct;
      next_r.outs[2]  = !next_r.outs[0] &&
                        em != spm_pkg::SPM_DIS;
      next_r.outs[3]  = em == spm_pkg::SPM_DN;
      next_r.outs[4]  = em != spm_pkg::SPM_DIS;
      next_r.outs[5]  = em == spm_pkg::SPM_DN ||
                        em == spm_pkg::SPM_UNATT;
      next_r.outs[6]  = em == spm_pkg::SPM_UP ||
                        em == spm_pkg::SPM_UNATT;
      next_r.outs[7]  = em == spm_pkg::SPM_UNATT;
      next_r.outs[8]  = em == spm_pkg::SPM_UNATT;
      next_r.outs[9]  = em == spm_pkg::SPM_UNATT;
      next_r.outs[10] = (em == spm_pkg::SPM_DN) ||
                        (em == spm_pkg::SPM_UNATT &&
                         next_r.iscc);
      next_r.outs[11] = 1'b0;

      // Read data
      case (wb_adr_i)
         `SPM_OFS_CTL: begin
            rd[`SPM_CTL_MODE]              = r.mode;
            rd[`SPM_CTL_ACT]               = r.act;
            rd[`SPM_CTL_PSEL_LO +: PSELW] = r.psel;
            rd[`SPM_CTL_DEV]               = r.dev;
         end
         `SPM_OFS_STS: begin
            rd[`SPM_STS_INIT] = r.initFlag;
            rd[`SPM_STS_DONE] = r.doneFlag;
            rd[`SPM_STS_BUSY] = r.mc == spm_pkg::SPM_BUSY;
            rd[`SPM_STS_MODE] = modeCode(r.active);
         end
         `SPM_OFS_PHY: rd[`SPM_PHY_ISCC] = r.iscc;
         `SPM_OFS_BRG: begin
            rd[`SPM_BRG_BUS] = r.capBus;
            rd[`SPM_BRG_DEV] = r.capDev;
            rd[`SPM_BRG_T1]  = r.outs[4];
         end
         default: begin
            for (int i = 0; i < NPART; i++) begin
               if (partHit[i])
                  rd[`SPM_PART_STATE] = r.partState[i];
            end
         end
      endcase
      next_r.wbDat = (wbReq && !wb_we_i) ? rd : 32'h0000_0000;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         r           <= '0;
         r.mode      <= `SPM_MODE_DIS;
         r.act       <= `SPM_ACT_NONE;
         r.dev       <= `SPM_DEV_RST;
         r.partState <= {NPART{`SPM_PART_ACTIVE}};
         r.mc        <= spm_pkg::SPM_IDLE;
         r.active    <= spm_pkg::SPM_DIS;
         r.hpAttn    <= HP_ATTN_NEG;
         r.hpRst     <= HP_RST_NEG;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Every output straight from the state register
   assign wb_dat_o            = r.wbDat;
   assign wb_ack_o            = r.wbAck;
   assign cplStb              = r.cplStb;
   assign cplDevNum           = r.cplDev;
   assign portMode            = r.active;
   assign modeBusy            = r.outs[0];
   assign portReset           = r.outs[1];
   assign ltssmEnable         = r.outs[2];
   assign ltssmDownstream     = r.outs[3];
   assign hdrType1            = r.outs[4];
   assign regDsProfile        = r.outs[5];
   assign linkUsProfile       = r.outs[6];
   assign ignoreHotReset      = r.outs[7];
   assign ignoreDlDown        = r.outs[8];
   assign ignoreSlotPwr       = r.outs[9];
   assign autoSpeedChgEn      = r.outs[10];
   assign capturedBus         = r.capBus;
   assign capturedDev         = r.capDev;
   assign hotplugAttentionInd = r.hpAttn;
   assign hotplugSlotReset    = r.hpRst;

endmodule : spm_port_mode

//--- spm_port_mode_chk.sv
// Concurrent checks on the port mode block, bound to its top module
`timescale 1ns/1ns
module spm_port_mode_chk #(
   parameter int LN = 20,   // Change length, no action
   parameter int LR = 25,   // Change length, reset action
   parameter bit HA = 1'b1, // Attention pin negated level
   parameter bit HR = 1'b1  // Slot reset pin negated level
) (
   input wire logic       clk,                 // Core clock
   input wire logic       rst,                 // Sync reset
   input wire logic       wb_cyc_i,            // Cycle
   input wire logic       wb_stb_i,            // Strobe
   input wire logic       wb_ack_o,            // Acknowledge
   input wire logic       cfgWrStb,            // Config write
   input wire logic       cplStb,              // Completion
   input wire logic       type0WrStb,          // Type 0 write
   input wire logic [3:0] portMode,            // One-hot mode
   input wire logic       modeBusy,            // Change busy
   input wire logic       ltssmEnable,         // Training on
   input wire logic       ltssmDownstream,     // Training downstream
   input wire logic       hdrType1,            // Type 1 header
   input wire logic       ignoreHotReset,      // Hot reset ignored
   input wire logic       hotplugAttentionInd, // Attention pin
   input wire logic       hotplugSlotReset,    // Slot reset pin
   input wire logic [4:0] capturedDev          // Bridge device number
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [31:0] busyCnt;
   // Length of the running mode change
   always_ff @(posedge clk) begin
      busyCnt <= (rst || !modeBusy) ? 32'h0000_0000 : busyCnt + 32'h0000_0001;
   end
   AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   AST_ACK1: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   AST_CPL: assert property (cfgWrStb |=> cplStb)
      else $error("completion missing after config write");
   AST_LAT: assert property ($fell(modeBusy) |-> busyCnt == LN || busyCnt == LR)
      else $error("mode change length wrong");
   AST_HDR: assert property ($stable(portMode) |-> hdrType1 == (portMode != 4'h1))
      else $error("header type does not follow mode");
   AST_LDN: assert property ($stable(portMode) |-> ltssmDownstream == (portMode == 4'h4))
      else $error("training direction does not follow mode");
   AST_LTS: assert property ($stable(portMode) && $stable(modeBusy)
      |-> ltssmEnable == (!modeBusy && portMode != 4'h1))
      else $error("training enable wrong");
   AST_UNA: assert property ($stable(portMode) |-> ignoreHotReset == (portMode == 4'h8))
      else $error("hot reset filter does not follow mode");
   AST_HP: assert property (portMode != 4'h4 && $past(portMode) != 4'h4
      |-> hotplugAttentionInd == HA && hotplugSlotReset == HR)
      else $error("hot-plug pin not negated");
   AST_DEV: assert property ($past(type0WrStb) && portMode == 4'h2 && $stable(portMode)
      |-> capturedDev == 5'h00)
      else $error("upstream device number not zero");
   AST_CAP: assert property (!$past(type0WrStb) |-> $stable(capturedDev))
      else $error("captured device number changed");
   COV_CHG: cover property ($fell(modeBusy));
   COV_CPL: cover property (cplStb);
   COV_UNA: cover property (portMode == 4'h8);
endmodule : spm_port_mode_chk
bind spm_port_mode spm_port_mode_chk #(.LN(LAT_NOACT), .LR(LAT_RESET),
   .HA(HP_ATTN_NEG), .HR(HP_RST_NEG)) chk (.clk(clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .cfgWrStb(cfgWrStb), .cplStb(cplStb), .type0WrStb(type0WrStb),
   .portMode(portMode), .modeBusy(modeBusy), .ltssmEnable(ltssmEnable),
   .ltssmDownstream(ltssmDownstream), .hdrType1(hdrType1),
   .ignoreHotReset(ignoreHotReset), .capturedDev(capturedDev),
   .hotplugAttentionInd(hotplugAttentionInd),
   .hotplugSlotReset(hotplugSlotReset));

//--- spm_link_partner.sv
// Link partner model: config write of device number, then Type 0 write
`timescale 1ns/1ns
module spm_link_partner #(
   parameter logic [7:0] BUS = 8'h5A // Bus number it assigns
) (
   input  wire logic       clk,         // Core clock
   input  wire logic       go,          // Start one sequence
   input  wire logic [4:0] dev,         // Device number to set
   output logic            cfgWrStb,    // Config write pulse
   output logic      [4:0] cfgWrDevNum, // Device number value
   output logic            type0WrStb,  // Type 0 write pulse
   output logic      [7:0] type0WrBus   // Bus number value
);
   logic [2:0] dly;
   initial begin
      {cfgWrStb, cfgWrDevNum, type0WrStb, type0WrBus, dly} = '0;
   end
   // Only one port is numbered here, so numbers stay unique
   // Type 0 write follows each device number change
   always @(posedge clk) begin
      cfgWrStb <= go;
      cfgWrDevNum <= go ? dev : ~cfgWrDevNum; // Toggles when not valid
      type0WrStb <= (dly == 3'h1);
      type0WrBus <= (dly == 3'h1) ? BUS : ~type0WrBus;
      dly <= go ? 3'h4 : ((dly != 3'h0) ? dly - 3'h1 : 3'h0);
   end
endmodule : spm_link_partner

//--- spm_port_mode_test.sv
// Self-checking bench of the port mode block
`timescale 1ns/1ns
`include "spm_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module spm_port_mode_test;
   localparam int LN = 20;
   localparam int LR = 25;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, go = 0;
   logic attn = 0, srst = 0, ack, busy, ase, hpa, cfgS, t0S;
   logic [7:0]  adr = 8'h00, t0B;
   logic [31:0] dat = 32'h0, rd, wdo, seed;
   logic [4:0]  pdev = 5'h00, cfgD, d, cpd, odev = 5'h00;
   logic [3:0]  pm, prof;
   int bad_count = 0, n_tests = 0, cycles = 0;
   spm_port_mode #(.LAT_NOACT(LN), .LAT_RESET(LR)) dut (.clk(clk),
      .rst(rst), .ce(1'b1), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wdo),
      .wb_ack_o(ack), .bootSwitchMode(2'h1), .cfgWrStb(cfgS),
      .cfgWrDevNum(cfgD), .type0WrStb(t0S), .type0WrBus(t0B),
      .dsAttnReq(attn), .dsSlotRstReq(srst), .cplStb(), .cplDevNum(cpd),
      .portMode(pm), .modeBusy(busy), .portReset(), .ltssmEnable(),
      .ltssmDownstream(), .hdrType1(), .regDsProfile(prof[0]),
      .linkUsProfile(prof[1]), .ignoreHotReset(),
      .ignoreDlDown(prof[2]), .ignoreSlotPwr(prof[3]),
      .autoSpeedChgEn(ase), .capturedBus(), .capturedDev(),
      .hotplugAttentionInd(hpa), .hotplugSlotReset());
   spm_link_partner lp (.clk(clk), .go(go), .dev(pdev), .cfgWrStb(cfgS),
      .cfgWrDevNum(cfgD), .type0WrStb(t0S), .type0WrBus(t0B));
   // Clock and hang guard
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         conclude();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // Control word from mode, action, partition and device number
   function automatic logic [31:0] ctl(input logic [1:0] m, a,
      input logic [2:0] p, input logic [4:0] v);
      return {11'h000, v, 5'h00, p, 2'h0, a, 2'h0, m};
   endfunction : ctl
   task automatic wbx(input logic w, input logic [7:0] a,
      input logic [31:0] v);
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, v};
      do @(posedge clk); while (ack !== 1'b1);
      rd = wdo;
      {cyc, stb, we} <= 3'h0;
   endtask : wbx
   task automatic wbusy(output int n);
      int t;
      t = 0;
      n = 0;
      while (busy !== 1'b1 && t < 6) begin
         @(posedge clk);
         t++;
      end
      while (busy === 1'b1 && n < 1000) begin
         n++;
         @(posedge clk);
      end
   endtask : wbusy
   // Read and clear both change flags
   task automatic flags();
      wbx(0, `SPM_OFS_STS, 32'h0);
      `CHK(rd[1:0], 2'h3)
      wbx(1, `SPM_OFS_STS, 32'h3);
   endtask : flags
   task automatic chg(input logic [7:0] a, input logic [31:0] v,
      input int lat, input logic [3:0] m);
      int n;
      wbx(1, a, v);
      wbusy(n);
      @(posedge clk);
      `CHK(n, lat)
      `CHK(pm, m)
      flags();
   endtask : chg
   task automatic pgo(input logic [4:0] v, input int lat,
      input logic [4:0] ed);
      int n;
      @(posedge clk);
      pdev <= v;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wbusy(n);
      `CHK(n, lat)
      `CHK(cpd, odev)
      odev = v;
      flags();
      wbx(0, `SPM_OFS_BRG, 32'h0);
      `CHK(rd[12:8], ed)
      `CHK(rd[7:0], 8'h5A)
      `CHK(rd[16], 1'b1)
   endtask : pgo
   task automatic tend(input int k);
      $display("test %0d done", k);
   endtask : tend
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // Main sequence
   initial begin
      seed = xs(32'h00006DCE);
      d = seed[4:0];
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      `CHK(pm, spm_pkg::SPM_UP)
      pgo(d, LN, 5'h00);
      attn <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(hpa, 1'b1)
      tend(1);
      chg(`SPM_OFS_CTL, ctl(2'h2, 2'h1, 3'h0, d), LR, spm_pkg::SPM_DN);
      seed = xs(seed);
      attn <= seed[0];
      srst <= seed[1];
      repeat (3) @(posedge clk);
      `CHK(hpa, ~seed[0])
      wbx(1, `SPM_OFS_CTL, ctl(2'h2, 2'h1, 3'h0, d));
      repeat (5) @(posedge clk);
      `CHK(busy, 1'b0)
      tend(2);
      pgo(d + 5'h01, LR, d + 5'h01);
      chg(`SPM_OFS_PART, 32'h0, LR, spm_pkg::SPM_DIS);
      chg(`SPM_OFS_CTL, ctl(2'h2, 2'h1, 3'h0, d + 5'h02), LR,
         spm_pkg::SPM_DIS);
      chg(`SPM_OFS_CTL, ctl(2'h2, 2'h1, 3'h1, d + 5'h02), LR,
         spm_pkg::SPM_DN);
      chg(`SPM_OFS_CTL, ctl(2'h0, 2'h0, 3'h1, d + 5'h02), LN,
         spm_pkg::SPM_DIS);
      tend(3);
      chg(`SPM_OFS_CTL, ctl(2'h3, 2'h0, 3'h1, d + 5'h02), LN,
         spm_pkg::SPM_UNATT);
      `CHK(prof, 4'hF)
      `CHK(ase, 1'b0)
      wbx(1, `SPM_OFS_PHY, 32'h1);
      repeat (3) @(posedge clk);
      `CHK(ase, 1'b1)
      wbx(0, 8'h40, 32'h0);
      `CHK(rd, 32'h0)
      tend(4);
      conclude();
   end
endmodule : spm_port_mode_test
